/* File: rtl/tspc_pkg.sv */
// Package with constants and types for the timer single pulse and capture block.
// Notes on behaviour
// R1: Software selects single pulse with mode 10 and pin function 11, kept fixed.
// R2: A software rise of the counter-on bit starts the pulse leading edge.
// R3: An active trigger pin edge sets the counter-on bit and starts the pulse.
// R4: On the counter-on rise the counter starts and the pulse output goes active.
// R5: The pulse ends whenever the counter-on bit is cleared by software or hardware.
// R6: A compare-A match clears the counter-on bit, so compare-A sets the width.
// R7: A compare-A match in single pulse mode raises the compare-A interrupt flag.
// R8: In single pulse mode the counter is zeroed only on a counter-on rise.
// R9: Single pulse mode ignores compare-P, clear select and duty/period swap.
// R10: Software selects capture with mode 01 and starts by raising counter-on.
// R11: Capture edge is rising, falling or both, chosen by the pin function bits.
// R12: Pin function 00 rising, 01 falling, 10 both, 11 capture disabled.
// R13: A selected capture edge copies the counter into compare-A and flags interrupt.
// R14: In capture mode the counter runs freely until counter-on falls.
// R15: A compare-P match in capture mode zeroes the counter and flags interrupt.
// R16: A compare-P value of zero lets the counter reach its maximum and wrap.
// R17: Pin function 11 blocks every capture while the counter keeps running.
// R18: Capture pin transitions capture even when the shared pin is an output.
// R19: Capture mode drives no output and ignores initial level, polarity, clear select.
// R20: Compare-A and compare-P matches have separate interrupt request flags.
// R21: The counter steps once per enabled tick; compares use current register values.
// R22: Capture pins are synchronised and edge detected, one capture per edge.
`default_nettype none
package tspc_pkg;
  localparam int CNT_W = 10;
  localparam int COMPARE_P_VALUE_W = 3;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] OFS_CTRL0 = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_CTRL1 = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_COMPARE_A_VALUE = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_STAT = 4'hc;
  localparam int C0_ON = 3;
  localparam int C0_TRG_EDGE = 4;
  localparam int C0_TICK_LO = 5;
  localparam int C0_TICK_HI = 6;
  localparam int C1_CCLR = 0;
  localparam int C1_DPX = 1;
  localparam int C1_POL = 2;
  localparam int C1_OC = 3;
  localparam int C1_IO_LO = 4;
  localparam int C1_IO_HI = 5;
  localparam int C1_M_LO = 6;
  localparam int C1_M_HI = 7;
  localparam int ST_AF = 0;
  localparam int ST_PF = 1;
  localparam logic [1:0] MODE_CAPTURE = 2'h1;
  localparam logic [1:0] MODE_PULSE = 2'h2;
  localparam logic [1:0] IO_RISE = 2'h0;
  localparam logic [1:0] IO_FALL = 2'h1;
  localparam logic [1:0] IO_BOTH = 2'h2;
  localparam logic [1:0] IO_PULSE = 2'h3;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [CNT_W-1:0] CNT_RST = 10'h000;
  localparam logic [CNT_W-1:0] CNT_MAX = 10'h3ff;
  localparam int TICK_W = 6;
  localparam int TICK_DIV1 = 4;
  localparam int TICK_DIV2 = 16;
  localparam int TICK_DIV3 = 64;
  typedef enum logic [1:0] {TSPC_IDLE, TSPC_WAIT} tspc_bus_t;
endpackage
`default_nettype wire

/* File: rtl/tspc_sync_edge.sv */
// Two-stage synchroniser with edge detection for one pin.
`timescale 1ns/1ps
`default_nettype none
module tspc_sync_edge
  import tspc_pkg::*;
(
  input  wire logic i_clk_sys,
  input  wire logic i_rst,
  input  wire logic i_pin,
  output logic      o_rise,
  output logic      o_fall
);
  logic meta_r;
  logic sync_r;
  logic last_r;

  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      last_r <= 1'b0;
    end
    else
    begin
      meta_r <= i_pin;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end

  assign o_rise = sync_r & ~last_r; // R22
  assign o_fall = ~sync_r & last_r; // R22
endmodule
`default_nettype wire

/* File: rtl/tspc_tick.sv */
// Timer tick generator dividing the system clock by a selectable ratio.
`timescale 1ns/1ps
`default_nettype none
module tspc_tick
  import tspc_pkg::*;
(
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst,
  input  wire logic [1:0] i_sel,
  output logic            o_tick
);
  logic [TICK_W-1:0] div_r;
  logic [TICK_W-1:0] lim;

  always_comb
  begin
    if (i_sel == 2'h1)
      lim = TICK_W'(TICK_DIV1 - 1);
    else if (i_sel == 2'h2)
      lim = TICK_W'(TICK_DIV2 - 1);
    else if (i_sel == 2'h3)
      lim = TICK_W'(TICK_DIV3 - 1);
    else
      lim = '0;
  end

  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
      div_r <= '0;
    else if (div_r >= lim)
      div_r <= '0;
    else
      div_r <= div_r + 1'b1;
  end

  assign o_tick = (div_r >= lim);
endmodule
`default_nettype wire

/* File: rtl/tspc_top.sv */
// Timer block with single pulse output and capture input modes.
//
// Our own choices: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module tspc_top
  import tspc_pkg::*;
(
  input  wire logic              i_clk_sys,
  input  wire logic              i_rst,
  input  wire logic [ADDR_W-1:0] i_avs_address,
  input  wire logic              i_avs_read,
  input  wire logic              i_avs_write,
  input  wire logic [DATA_W-1:0] i_avs_writedata,
  input  wire logic [3:0]        i_avs_byteenable,
  output logic [DATA_W-1:0]      o_avs_readdata,
  output logic                   o_avs_waitrequest,
  output logic [1:0]             o_avs_response,
  input  wire logic              i_external_trigger_pin,
  input  wire logic              i_capture_pin_zero,
  input  wire logic              i_capture_pin_one,
  output logic                   o_timer_out,
  output logic                   o_timer_out_en,
  output logic                   o_compare_a_irq,
  output logic                   o_compare_p_irq
);
  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  logic [7:0]       ctrl0_r;
  logic [7:0]       timer_control_one_r;
  logic [CNT_W-1:0] compare_a_value_r;
  logic [CNT_W-1:0] cnt_r;
  logic             compare_a_flag_r;
  logic             compare_p_flag_r;
  logic             on_last_r;
  logic             pulse_r;
  logic [DATA_W-1:0] rdata_r;
  tspc_bus_t        bus_r;

  logic             counter_on_bit;
  logic [1:0]       mode_sel;
  logic [1:0]       pin_fn;
  logic [COMPARE_P_VALUE_W-1:0] compare_p_value;
  logic             tick;
  logic             trg_rise;
  logic             trg_fall;
  logic             c0_rise;
  logic             c0_fall;
  logic             c1_rise;
  logic             c1_fall;
  logic             in_pulse;
  logic             in_cap;
  logic             on_rise;
  logic             match_a;
  logic             match_p;
  logic             cap_edge;
  logic             trig;
  logic             wr_go;
  logic             sw_on_clr;
  logic             sw_on_set;

  assign counter_on_bit = ctrl0_r[C0_ON];
  assign compare_p_value = ctrl0_r[COMPARE_P_VALUE_W-1:0];
  assign mode_sel = {timer_control_one_r[C1_M_HI], timer_control_one_r[C1_M_LO]};
  assign pin_fn = {timer_control_one_r[C1_IO_HI], timer_control_one_r[C1_IO_LO]};
  assign in_pulse = (mode_sel == MODE_PULSE) && (pin_fn == IO_PULSE); // R1
  assign in_cap = (mode_sel == MODE_CAPTURE); // R10

  // ---------------------------------------------------------------
  // Tick and pin edges
  // ---------------------------------------------------------------
  tspc_tick u_tick (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_sel     (ctrl0_r[C0_TICK_HI:C0_TICK_LO]),
    .o_tick    (tick)
  );

  tspc_sync_edge u_trg (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_pin     (i_external_trigger_pin),
    .o_rise    (trg_rise),
    .o_fall    (trg_fall)
  );

  tspc_sync_edge u_cap0 (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_pin     (i_capture_pin_zero),
    .o_rise    (c0_rise),
    .o_fall    (c0_fall)
  );

  tspc_sync_edge u_cap1 (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_pin     (i_capture_pin_one),
    .o_rise    (c1_rise),
    .o_fall    (c1_fall)
  );

  // ---------------------------------------------------------------
  // Event decode
  // ---------------------------------------------------------------
  assign trig = ctrl0_r[C0_TRG_EDGE] ? trg_fall : trg_rise;
  assign on_rise = counter_on_bit & ~on_last_r; // R2

  assign match_a = tick && counter_on_bit && !on_rise
                && (cnt_r == compare_a_value_r); // R21
  // Only the top three counter bits meet compare-P; zero means full wrap.
  assign match_p = tick && counter_on_bit && !on_rise
                && (compare_p_value != '0)
                && (cnt_r[CNT_W-1:CNT_W-COMPARE_P_VALUE_W] == compare_p_value)
                && (cnt_r[CNT_W-COMPARE_P_VALUE_W-1:0] == '0); // R16

  always_comb
  begin
    cap_edge = 1'b0;
    case (pin_fn)
      IO_RISE: cap_edge = c0_rise | c1_rise; // R12
      IO_FALL: cap_edge = c0_fall | c1_fall; // R12
      IO_BOTH: cap_edge = c0_rise | c1_rise | c0_fall | c1_fall; // R11
      default: cap_edge = 1'b0; // R17
    endcase
    // Edges count regardless of how the shared pin is driven.
    cap_edge = cap_edge & in_cap & counter_on_bit; // R18
  end

  // ---------------------------------------------------------------
  // Register bus
  // ---------------------------------------------------------------
  assign wr_go = (bus_r == TSPC_WAIT) && i_avs_write;
  assign o_avs_waitrequest = (i_avs_read || i_avs_write)
                          && (bus_r != TSPC_WAIT);
  assign o_avs_readdata = rdata_r;
  assign o_avs_response = 2'h0;

  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
      bus_r <= TSPC_IDLE;
    else if (bus_r == TSPC_WAIT)
      bus_r <= TSPC_IDLE;
    else if (i_avs_read || i_avs_write)
      bus_r <= TSPC_WAIT;
  end

  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
      rdata_r <= '0;
    else if ((i_avs_read || i_avs_write) && (bus_r != TSPC_WAIT))
    begin
      if (i_avs_address == OFS_CTRL0)
        rdata_r <= {24'h0, ctrl0_r};
      else if (i_avs_address == OFS_CTRL1)
        rdata_r <= {24'h0, timer_control_one_r};
      else if (i_avs_address == OFS_COMPARE_A_VALUE)
        rdata_r <= {22'h0, compare_a_value_r};
      else if (i_avs_address == OFS_STAT)
        rdata_r <= {6'h0, cnt_r, 13'h0, pulse_r,
                    compare_p_flag_r, compare_a_flag_r};
      else
        rdata_r <= '0;
    end
  end

  assign sw_on_set = wr_go && (i_avs_address == OFS_CTRL0)
                  && i_avs_byteenable[0] && i_avs_writedata[C0_ON];
  assign sw_on_clr = wr_go && (i_avs_address == OFS_CTRL0)
                  && i_avs_byteenable[0] && !i_avs_writedata[C0_ON];

  // ---------------------------------------------------------------
  // Control registers and counter-on bit
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
      ctrl0_r <= CTRL_RST;
    else
    begin
      if (wr_go && (i_avs_address == OFS_CTRL0) && i_avs_byteenable[0])
        ctrl0_r <= i_avs_writedata[7:0];
      if (in_pulse && trig && !counter_on_bit && !sw_on_clr)
        ctrl0_r[C0_ON] <= 1'b1; // R3
      else if (in_pulse && match_a && !sw_on_set)
        ctrl0_r[C0_ON] <= 1'b0; // R6
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
      timer_control_one_r <= CTRL_RST;
    else if (wr_go && (i_avs_address == OFS_CTRL1) && i_avs_byteenable[0])
      timer_control_one_r <= i_avs_writedata[7:0];
  end

  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
      on_last_r <= 1'b0;
    else
      on_last_r <= counter_on_bit;
  end

  // ---------------------------------------------------------------
  // Counter
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
      cnt_r <= CNT_RST;
    else if (on_rise)
      cnt_r <= CNT_RST; // R8
    else if (counter_on_bit && tick)
    begin
      if (in_cap && match_p)
        cnt_r <= CNT_RST; // R15
      else
        cnt_r <= cnt_r + 1'b1; // R14
    end
  end

  // ---------------------------------------------------------------
  // Compare-A register and capture
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
      compare_a_value_r <= CNT_RST;
    else if (cap_edge)
      compare_a_value_r <= cnt_r; // R13
    else if (wr_go && (i_avs_address == OFS_COMPARE_A_VALUE))
    begin
      if (i_avs_byteenable[0])
        compare_a_value_r[7:0] <= i_avs_writedata[7:0];
      if (i_avs_byteenable[1])
        compare_a_value_r[9:8] <= i_avs_writedata[9:8];
    end
  end

  // ---------------------------------------------------------------
  // Interrupt flags, write one to clear, set wins
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
      compare_a_flag_r <= 1'b0;
    else if ((in_pulse && match_a) || cap_edge)
      compare_a_flag_r <= 1'b1; // R7
    else if (wr_go && (i_avs_address == OFS_STAT) && i_avs_byteenable[0]
             && i_avs_writedata[ST_AF])
      compare_a_flag_r <= 1'b0; // R20
  end

  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
      compare_p_flag_r <= 1'b0;
    else if (in_cap && match_p)
      compare_p_flag_r <= 1'b1; // R15 R9
    else if (wr_go && (i_avs_address == OFS_STAT) && i_avs_byteenable[0]
             && i_avs_writedata[ST_PF])
      compare_p_flag_r <= 1'b0; // R20
  end

  assign o_compare_a_irq = compare_a_flag_r;
  assign o_compare_p_irq = compare_p_flag_r;

  // ---------------------------------------------------------------
  // Pulse output
  // ---------------------------------------------------------------
  // Active level follows the initial-level bit, inverted by polarity.
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
      pulse_r <= 1'b0;
    else
      pulse_r <= in_pulse && counter_on_bit; // R4 R5
  end

  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
      o_timer_out <= 1'b0;
    else
      o_timer_out <= in_pulse && ((in_pulse && counter_on_bit) // R4 R5
                   ? timer_control_one_r[C1_OC]
                   : ~timer_control_one_r[C1_OC])
                   ^ timer_control_one_r[C1_POL];
  end

  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
      o_timer_out_en <= 1'b0;
    else
      o_timer_out_en <= in_pulse; // R19
  end
endmodule
`default_nettype wire

/* File: testbench/tspc_chk.sv */
// Checker for bus, flag and output relations of the timer block.
`timescale 1ns/1ps
`default_nettype none
module tspc_chk
  import tspc_pkg::*;
(
  input wire logic              i_clk_sys,
  input wire logic              i_rst,
  input wire logic [ADDR_W-1:0] i_avs_address,
  input wire logic              i_avs_read,
  input wire logic              i_avs_write,
  input wire logic [DATA_W-1:0] i_avs_writedata,
  input wire logic [3:0]        i_avs_byteenable,
  input wire logic [DATA_W-1:0] o_avs_readdata,
  input wire logic              o_avs_waitrequest,
  input wire logic [1:0]        o_avs_response,
  input wire logic              i_external_trigger_pin,
  input wire logic              i_capture_pin_zero,
  input wire logic              i_capture_pin_one,
  input wire logic              o_timer_out,
  input wire logic              o_timer_out_en,
  input wire logic              o_compare_a_irq,
  input wire logic              o_compare_p_irq
);
  logic       req;
  logic       acc;
  logic       wr_c1;
  logic       clr_a;
  logic       clr_p;
  logic [3:0] since_r;
  assign req = i_avs_read | i_avs_write;
  assign acc = i_avs_write & ~o_avs_waitrequest;
  assign wr_c1 = acc & (i_avs_address == OFS_CTRL1);
  assign clr_a = acc & (i_avs_address == OFS_STAT) & i_avs_writedata[ST_AF];
  assign clr_p = acc & (i_avs_address == OFS_STAT) & i_avs_writedata[ST_PF];
  // Counts clocks since the last change on either capture pin.
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
      since_r <= 4'hf;
    else if ($changed(i_capture_pin_zero) || $changed(i_capture_pin_one))
      since_r <= 4'h0;
    else if (since_r != 4'hf)
      since_r <= since_r + 4'h1;
  end
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);
  sequence s_out_flip;
    ##[0:2] $changed(o_timer_out);
  endsequence
  a_wait_first: assert property ($rose(req) |-> o_avs_waitrequest)
    else $error("waitrequest low in first cycle of a request");
  a_wait_one: assert property (req && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("waitrequest held beyond one cycle");
  a_resp_okay: assert property (o_avs_response == 2'h0)
    else $error("response code not okay");
  a_sticky_a: assert property (o_compare_a_irq && !clr_a |=> o_compare_a_irq)
    else $error("compare A flag dropped without clear");
  a_sticky_p: assert property (o_compare_p_irq && !clr_p |=> o_compare_p_irq)
    else $error("compare P flag dropped without clear");
  a_en_cause: assert property ($changed(o_timer_out_en) |->
    $past(wr_c1) || $past(wr_c1, 2) || $past(wr_c1, 3))
    else $error("output enable changed without a mode write");
  a_out_idle: assert property (!o_timer_out_en && !$past(o_timer_out_en) &&
    !$past(o_timer_out_en, 2) |-> !o_timer_out)
    else $error("timer output active outside pulse mode");
  a_pulse_end: assert property (o_timer_out_en && $rose(o_compare_a_irq)
    |-> s_out_flip)
    else $error("pulse not ended by compare A match");
  a_p_quiet: assert property (o_timer_out_en && $past(o_timer_out_en)
    |-> !$rose(o_compare_p_irq))
    else $error("compare P flag raised in pulse mode");
  a_cap_cause: assert property ($rose(o_compare_a_irq) && !o_timer_out_en
    |-> since_r < 4'h8)
    else $error("capture flag without a recent pin edge");
endmodule
bind tspc_top tspc_chk u_chk (.*);
`default_nettype wire

/* File: testbench/tspc_pins.sv */
// Model of the trigger and capture pins outside the timer block.
`timescale 1ns/1ps
`default_nettype none
module tspc_pins
(
  input  wire logic i_clk_sys,
  output logic      o_trig,
  output logic      o_cap0,
  output logic      o_cap1
);
  initial
  begin
    o_trig = 1'b0;
    o_cap0 = 1'b0;
    o_cap1 = 1'b0;
  end
  // Each level is held six clocks so the synchroniser sees every edge.
  task automatic drive(input int which, input logic lvl);
    @(posedge i_clk_sys);
    case (which)
      0: o_trig <= lvl;
      1: o_cap0 <= lvl;
      default: o_cap1 <= lvl;
    endcase
    repeat (6) @(posedge i_clk_sys);
  endtask
endmodule
`default_nettype wire

/* File: testbench/tb_timer_single_pulse_and_capture.sv */
// Testbench for the timer single pulse and capture block.
`timescale 1ns/1ps
`default_nettype none
module tb_timer_single_pulse_and_capture
  import tspc_pkg::*;
;
  logic              i_clk_sys = 1'b0;
  logic              i_rst = 1'b1;
  logic [ADDR_W-1:0] i_avs_address = 4'h0;
  logic              i_avs_read = 1'b0;
  logic              i_avs_write = 1'b0;
  logic [DATA_W-1:0] i_avs_writedata = 32'h0;
  logic [3:0]        i_avs_byteenable = 4'hf;
  logic [DATA_W-1:0] o_avs_readdata;
  logic              o_avs_waitrequest;
  logic [1:0]        o_avs_response;
  logic              i_external_trigger_pin;
  logic              i_capture_pin_zero;
  logic              i_capture_pin_one;
  logic              o_timer_out;
  logic              o_timer_out_en;
  logic              o_compare_a_irq;
  logic              o_compare_p_irq;
  logic [31:0]       rd;
  logic [9:0]        c0;
  logic [9:0]        cs;
  logic [31:0]       cv;
  int                n;
  int                n_fail = 0;
  int                n_tests = 0;
  always #20 i_clk_sys = ~i_clk_sys;
  tspc_top dut (.*);
  tspc_pins pins (.i_clk_sys(i_clk_sys), .o_trig(i_external_trigger_pin),
    .o_cap0(i_capture_pin_zero), .o_cap1(i_capture_pin_one));
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge i_clk_sys);
    i_avs_address <= a;
    i_avs_writedata <= d;
    i_avs_write <= w;
    i_avs_read <= !w;
    do
    begin
      @(posedge i_clk_sys);
      k++;
    end
    while (o_avs_waitrequest !== 1'b0 && k < 50);
    if (k == 50)
      n_fail++;
    rd = o_avs_readdata;
    i_avs_write <= 1'b0;
    i_avs_read <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdc(input string nm, input logic [3:0] a, input logic [31:0] m,
    input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, e, rd & m);
  endtask
  task automatic wirq(input logic p, input int lim);
    n = 0;
    while ((p ? o_compare_p_irq : o_compare_a_irq) !== 1'b1 && n < lim)
    begin
      @(posedge i_clk_sys);
      n++;
    end
  endtask
  initial
  begin
    repeat (20000) @(posedge i_clk_sys);
    n_fail++;
    tally_and_finish();
  end
  initial
  begin
    repeat (12) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    for (int i = 0; i < 4; i++)
      rdc("reset_value", 4'(i * 4), 32'hffffffff, 32'h0);
    wr(4'h2, 32'hff);
    rdc("unmapped", 4'h2, 32'hffffffff, 32'h0);
    rdc("ctrl0_kept", OFS_CTRL0, 32'hffffffff, 32'h0);
    wr(OFS_CTRL1, 32'hbb);
    wr(OFS_COMPARE_A_VALUE, 32'hc8);
    wr(OFS_CTRL0, 32'h09);
    repeat (3) @(posedge i_clk_sys);
    chk("out_lead", 32'h1, {31'h0, o_timer_out});
    chk("out_en", 32'h1, {31'h0, o_timer_out_en});
    rdc("pulse_busy", OFS_STAT, 32'h4, 32'h4);
    wirq(1'b0, 260);
    chk("width", 32'h1, {31'h0, n >= 190});
    chk("a_flag", 32'h1, {31'h0, o_compare_a_irq});
    repeat (3) @(posedge i_clk_sys);
    chk("out_trail", 32'h0, {31'h0, o_timer_out});
    bus(1'b0, OFS_STAT, 32'h0);
    chk("cnt_kept", 32'h1, {31'h0, rd[25:16] >= 10'h0c8});
    rdc("on_cleared", OFS_CTRL0, 32'h8, 32'h0);
    rdc("p_ignored", OFS_STAT, 32'h2, 32'h0);
    rdc("pulse_idle", OFS_STAT, 32'h4, 32'h0);
    wr(OFS_STAT, 32'h1);
    rdc("a_cleared", OFS_STAT, 32'h3, 32'h0);
    wr(OFS_CTRL1, 32'hbc);
    wr(OFS_CTRL0, 32'h08);
    repeat (3) @(posedge i_clk_sys);
    chk("inv_lead", 32'h0, {31'h0, o_timer_out});
    bus(1'b0, OFS_STAT, 32'h0);
    chk("cnt_restart", 32'h1, {31'h0, rd[25:16] < 10'h00a});
    wr(OFS_CTRL0, 32'h0);
    repeat (3) @(posedge i_clk_sys);
    chk("sw_trail", 32'h1, {31'h0, o_timer_out});
    rdc("sw_no_flag", OFS_STAT, 32'h1, 32'h0);
    wr(OFS_CTRL1, 32'hb8);
    wr(OFS_COMPARE_A_VALUE, 32'h14);
    pins.drive(0, 1'b1);
    chk("trig_out", 32'h1, {31'h0, o_timer_out});
    wirq(1'b0, 40);
    chk("trig_flag", 32'h1, {31'h0, o_compare_a_irq});
    wr(OFS_STAT, 32'h1);
    pins.drive(0, 1'b0);
    rdc("trig_fall", OFS_CTRL0, 32'h8, 32'h0);
    wr(OFS_CTRL0, 32'h10);
    pins.drive(0, 1'b1);
    rdc("fall_sel_rise", OFS_CTRL0, 32'h8, 32'h0);
    pins.drive(0, 1'b0);
    chk("fall_trig_out", 32'h1, {31'h0, o_timer_out});
    wirq(1'b0, 40);
    chk("fall_trig_flag", 32'h1, {31'h0, o_compare_a_irq});
    wr(OFS_STAT, 32'h1);
    wr(OFS_CTRL1, 32'h4d);
    repeat (3) @(posedge i_clk_sys);
    chk("cap_out", 32'h0, {31'h0, o_timer_out});
    chk("cap_en", 32'h0, {31'h0, o_timer_out_en});
    wr(OFS_CTRL0, 32'h68);
    bus(1'b0, OFS_STAT, 32'h0);
    cs = rd[25:16];
    for (int f = 0; f < 4; f++)
    begin
      wr(OFS_CTRL1, 32'h4d | (32'(f) << 4));
      wr(OFS_STAT, 32'h3);
      bus(1'b0, OFS_STAT, 32'h0);
      c0 = rd[25:16];
      pins.drive(1 + f % 2, 1'b1);
      rdc("cap_rise", OFS_STAT, 32'h1, {31'h0, f == 0 || f == 2});
      bus(1'b0, OFS_COMPARE_A_VALUE, 32'h0);
      cv = rd;
      bus(1'b0, OFS_STAT, 32'h0);
      if (f == 0)
        chk("compare_a_value_win", 32'h1, {31'h0, cv >= c0 && cv <= rd[25:16]});
      wr(OFS_STAT, 32'h3);
      pins.drive(1 + f % 2, 1'b0);
      rdc("cap_fall", OFS_STAT, 32'h1, {31'h0, f == 1 || f == 2});
    end
    bus(1'b0, OFS_STAT, 32'h0);
    chk("free_run", 32'h1, {31'h0, rd[25:16] > cs});
    wr(OFS_CTRL0, 32'h0);
    wr(OFS_STAT, 32'h3);
    wr(OFS_CTRL0, 32'h09);
    wirq(1'b1, 300);
    chk("p_time", 32'h1, {31'h0, n >= 110 && n < 300});
    chk("p_irq", 32'h1, {31'h0, o_compare_p_irq});
    bus(1'b0, OFS_STAT, 32'h0);
    chk("p_reset", 32'h1, {31'h0, rd[25:16] < 10'h014});
    chk("p_separate", 32'h0, {31'h0, rd[0]});
    wr(OFS_CTRL0, 32'h0);
    wr(OFS_STAT, 32'h3);
    wr(OFS_CTRL0, 32'h08);
    repeat (900) @(posedge i_clk_sys);
    bus(1'b0, OFS_STAT, 32'h0);
    chk("p0_run", 32'h1, {31'h0, rd[25:16] > 10'h320});
    chk("p0_flag", 32'h0, {31'h0, rd[1]});
    for (int s = 1; s < 3; s++)
    begin
      wr(OFS_CTRL0, 32'h0);
      wr(OFS_CTRL0, 32'h08 | (32'(s) << 5));
      repeat (400) @(posedge i_clk_sys);
      bus(1'b0, OFS_STAT, 32'h0);
      cv = rd[25:16] * (s == 1 ? TICK_DIV1 : TICK_DIV2);
      chk("tick_rate", 32'h1, {31'h0, cv >= 32'h178 && cv <= 32'h1a0});
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
